// ==== logic/radio_ctrl_pkg.sv ====
`default_nettype none

package radio_ctrl_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_STATE_CMD = 8'h00;
	localparam logic [7:0] OFS_PIN_CTRL  = 8'h01;
	localparam logic [7:0] OFS_EVT_MASK  = 8'h02;
	localparam logic [7:0] OFS_EVT_STAT  = 8'h03;
	localparam logic [7:0] OFS_CHAN      = 8'h04;
	localparam logic [7:0] OFS_PART      = 8'h05;
	localparam logic [7:0] OFS_VERSION   = 8'h06;
	localparam logic [7:0] OFS_MAKER_LO  = 8'h07;
	localparam logic [7:0] OFS_MAKER_HI  = 8'h08;
	localparam logic [7:0] OFS_HDR       = 8'h09;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int POS_RADIO_RST   = 0;
	localparam int POS_SLEEP_TX    = 1;
	localparam int POS_MEAS_REQ    = 7;
	localparam int CMD_W           = 5;
	localparam int CHAN_W          = 5;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0]        RST_MASK  = 8'h00;
	localparam logic [CHAN_W-1:0] RST_CHAN  = 5'h0B;

	// ----------------------------------------
	// Identification, values arbitrary
	// ----------------------------------------
	localparam logic [7:0] ID_PART     = 8'h5A;
	localparam logic [7:0] ID_VERSION  = 8'h01;
	localparam logic [7:0] ID_MAKER_LO = 8'h3C;
	localparam logic [7:0] ID_MAKER_HI = 8'h00;

	// ----------------------------------------
	// Status codes
	// ----------------------------------------
	localparam logic [CMD_W-1:0] STS_BUSY_RX  = 5'h01;
	localparam logic [CMD_W-1:0] STS_BUSY_TX  = 5'h02;
	localparam logic [CMD_W-1:0] STS_RX       = 5'h06;
	localparam logic [CMD_W-1:0] STS_IDLE     = 5'h08;
	localparam logic [CMD_W-1:0] STS_SYNTH_ON = 5'h09;
	localparam logic [CMD_W-1:0] STS_SLEEP    = 5'h0F;
	localparam logic [CMD_W-1:0] STS_TRANSIT  = 5'h1F;

	// ----------------------------------------
	// Commands
	// ----------------------------------------
	localparam logic [CMD_W-1:0] CMD_NOP         = 5'h00;
	localparam logic [CMD_W-1:0] CMD_TX_START    = 5'h02;
	localparam logic [CMD_W-1:0] CMD_FORCE_IDLE  = 5'h03;
	localparam logic [CMD_W-1:0] CMD_FORCE_SYNTH = 5'h04;
	localparam logic [CMD_W-1:0] CMD_RX_ON       = 5'h06;
	localparam logic [CMD_W-1:0] CMD_IDLE        = 5'h08;
	localparam logic [CMD_W-1:0] CMD_SYNTH_ON    = 5'h09;

	// ----------------------------------------
	// Events, bit index and vector base
	// ----------------------------------------
	localparam int EV_LOCK     = 0;
	localparam int EV_UNLOCK   = 1;
	localparam int EV_RX_START = 2;
	localparam int EV_RX_DONE  = 3;
	localparam int EV_MEAS     = 4;
	localparam int EV_ADDR     = 5;
	localparam int EV_TX_DONE  = 6;
	localparam int EV_AWAKE    = 7;
	localparam logic [6:0] VEC_BASE = 7'h39;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int WAKE_TIME_NS  = 240000;
	localparam int REG_SETTLE_NS = 1000;
	localparam int WAKE_CYC      = WAKE_TIME_NS / CLK_PERIOD_NS;
	localparam int REG_CYC       = (REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 16;

	typedef enum logic [8:0] {
		ST_RESET    = 9'b000000001,
		ST_SLEEP    = 9'b000000010,
		ST_WAKE     = 9'b000000100,
		ST_IDLE     = 9'b000001000,
		ST_REG_UP   = 9'b000010000,
		ST_SYNTH_ON = 9'b000100000,
		ST_RX       = 9'b001000000,
		ST_BUSY_RX  = 9'b010000000,
		ST_BUSY_TX  = 9'b100000000
	} radio_state_t;

endpackage

`default_nettype wire

// ==== logic/radio_state_control_irq.sv ====
// Contract
// RULE1 - Eight events on vectors 57..64; lowest pending vector number wins.
// RULE2 - Awake event when idle-clocked is reached from sleep or reset.
// RULE3 - Unlock event; power amplifier off at once if transmitting.
// RULE4 - Receive-start event enters busy-receive with header byte readable.
// RULE5 - Finished energy or channel measurement raises measurement-done event.
// RULE6 - All event mask bits cleared after reset.
// RULE7 - Controller should enable awake event during initialization.
// RULE8 - Read-only part, version and two maker identification registers.
// RULE9 - State changes by command field or control bits; status readable.
// RULE10 - Status 0x1F during transitions; no new request meanwhile.
// RULE11 - Rising sleep/transmit bit: idle to sleep, synthesizer-on to transmit.
// RULE12 - Clearing sleep/transmit bit in sleep returns to idle-clocked.
// RULE13 - Module reset bit restores registers and forces idle-clocked, even asleep.
// RULE14 - Forced idle aborts activity, goes idle at once, not from sleep.
// RULE15 - Plain idle during busy activity waits until the activity completes.
// RULE16 - Forced synthesizer-on leaves receive or transmit quickly, not in sleep.
// RULE17 - Controller confirms every state change by reading status.
// RULE18 - Sleep only from idle via bit; keeps registers, clears buffer and cipher.
// RULE19 - Idle-clocked keeps storage accessible, analog front end disabled.
// RULE20 - From idle enable regulator, then synthesizer; lock event on settling.
// RULE21 - Receive-on reports receive at once; frames only after lock.
// RULE22 - Sticky pending bits, cleared by writing one or service; mask gates.
// RULE23 - Module reset bit self-clears; sleep/transmit bit holds its value.
// RULE24 - Frame end returns to receive or synthesizer-on unless idle pending.
//
// Our own choices: the address map and the plain strobed port.
`default_nettype none

module radio_state_control_irq #(
	parameter int WAKE_CYC = radio_ctrl_pkg::WAKE_CYC
) (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_ce,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	input  wire logic       i_synth_lock,
	input  wire logic       i_phr_valid,
	input  wire logic [7:0] i_rx_hdr_byte,
	input  wire logic       i_addr_match,
	input  wire logic       i_rx_frame_done,
	input  wire logic       i_tx_frame_done,
	input  wire logic       i_meas_done,
	input  wire logic       i_vec_ack,
	output logic            o_meas_start,
	output logic            o_analog_reg_en,
	output logic            o_synth_en,
	output logic            o_rx_en,
	output logic            o_pa_en,
	output logic            o_buf_clear,
	output logic            o_cipher_clear,
	output logic      [7:0] o_event_pending,
	output logic            o_irq_req,
	output logic      [6:0] o_irq_vector
);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic                                  wr_cmd;
	logic                                  wr_pin;
	logic                                  wr_mask;
	logic                                  wr_stat;
	logic                                  wr_chan;
	logic                                  soft_rst;
	logic                                  any_rst;
	logic [radio_ctrl_pkg::CMD_W-1:0]      cmd;

	assign wr_cmd  = i_wr && (i_addr == radio_ctrl_pkg::OFS_STATE_CMD);
	assign wr_pin  = i_wr && (i_addr == radio_ctrl_pkg::OFS_PIN_CTRL);
	assign wr_mask = i_wr && (i_addr == radio_ctrl_pkg::OFS_EVT_MASK);
	assign wr_stat = i_wr && (i_addr == radio_ctrl_pkg::OFS_EVT_STAT);
	assign wr_chan = i_wr && (i_addr == radio_ctrl_pkg::OFS_CHAN);
	// Reset bit is never stored, so it reads back as zero
	assign soft_rst = wr_pin && i_wdata[radio_ctrl_pkg::POS_RADIO_RST]; // RULE23
	assign any_rst  = !i_rstn || (soft_rst && i_ce); // RULE13
	assign cmd = wr_cmd ? i_wdata[radio_ctrl_pkg::CMD_W-1:0] : radio_ctrl_pkg::CMD_NOP;

	// ----------------------------------------
	// Pin control
	// ----------------------------------------
	logic sleep_tx_ff;
	logic sleep_tx_q_ff;
	logic slp_rise;

	// Module reset leaves this bit alone; software must clear it
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			sleep_tx_ff   <= 1'b0;
			sleep_tx_q_ff <= 1'b0;
		end else if (i_ce) begin
			if (wr_pin) begin
				sleep_tx_ff <= i_wdata[radio_ctrl_pkg::POS_SLEEP_TX]; // RULE23
			end
			sleep_tx_q_ff <= sleep_tx_ff;
		end
	end

	assign slp_rise = sleep_tx_ff && !sleep_tx_q_ff;

	// ----------------------------------------
	// Synthesizer lock tracking
	// ----------------------------------------
	logic lock_q_ff;
	logic lock_now;
	logic unlock_now;

	always_ff @(posedge i_ref_clk) begin
		if (any_rst) begin
			lock_q_ff <= 1'b0;
		end else if (i_ce) begin
			lock_q_ff <= i_synth_lock && o_synth_en;
		end
	end

	assign lock_now   = o_synth_en && i_synth_lock && !lock_q_ff; // RULE20
	assign unlock_now = lock_q_ff && !(o_synth_en && i_synth_lock); // RULE3

	// ----------------------------------------
	// State machine
	// ----------------------------------------
	radio_ctrl_pkg::radio_state_t      state_ff;
	radio_ctrl_pkg::radio_state_t      nxt_state;
	logic                              pend_idle_ff;
	logic                              nxt_pend_idle;
	logic [radio_ctrl_pkg::CNT_W-1:0]  cnt_ff;
	logic                              wake_done;
	logic                              reg_done;
	logic                              go_idle;
	logic                              rx_begin;

	assign wake_done = (cnt_ff == radio_ctrl_pkg::CNT_W'(WAKE_CYC - 1));
	assign reg_done  = (cnt_ff == radio_ctrl_pkg::CNT_W'(radio_ctrl_pkg::REG_CYC - 1));
	assign go_idle   = (cmd == radio_ctrl_pkg::CMD_IDLE) ||
	                   (cmd == radio_ctrl_pkg::CMD_FORCE_IDLE);
	// Reception only starts with the synthesizer locked
	assign rx_begin  = (state_ff == radio_ctrl_pkg::ST_RX) && i_phr_valid &&
	                   i_synth_lock; // RULE21

	always_comb begin
		nxt_state     = state_ff;
		nxt_pend_idle = pend_idle_ff;
		case (state_ff) // RULE9
			radio_ctrl_pkg::ST_RESET: begin
				nxt_state = radio_ctrl_pkg::ST_IDLE; // RULE19
			end
			radio_ctrl_pkg::ST_SLEEP: begin
				if (!sleep_tx_ff) begin
					nxt_state = radio_ctrl_pkg::ST_WAKE; // RULE12
				end
			end
			radio_ctrl_pkg::ST_WAKE: begin
				if (wake_done) begin
					nxt_state = radio_ctrl_pkg::ST_IDLE; // RULE12
				end
			end
			radio_ctrl_pkg::ST_IDLE: begin
				if (slp_rise) begin
					nxt_state = radio_ctrl_pkg::ST_SLEEP; // RULE11 RULE18
				end else if (cmd == radio_ctrl_pkg::CMD_SYNTH_ON) begin
					nxt_state = radio_ctrl_pkg::ST_REG_UP; // RULE20
				end
			end
			radio_ctrl_pkg::ST_REG_UP: begin
				if (go_idle) begin
					nxt_state = radio_ctrl_pkg::ST_IDLE; // RULE14
				end else if (reg_done) begin
					nxt_state = radio_ctrl_pkg::ST_SYNTH_ON; // RULE20
				end
			end
			radio_ctrl_pkg::ST_SYNTH_ON: begin
				if (go_idle) begin
					nxt_state = radio_ctrl_pkg::ST_IDLE;
				end else if (slp_rise || (cmd == radio_ctrl_pkg::CMD_TX_START)) begin
					nxt_state = radio_ctrl_pkg::ST_BUSY_TX; // RULE11
				end else if (cmd == radio_ctrl_pkg::CMD_RX_ON) begin
					nxt_state = radio_ctrl_pkg::ST_RX; // RULE21
				end
			end
			radio_ctrl_pkg::ST_RX: begin
				if (go_idle) begin
					nxt_state = radio_ctrl_pkg::ST_IDLE;
				end else if ((cmd == radio_ctrl_pkg::CMD_SYNTH_ON) ||
				             (cmd == radio_ctrl_pkg::CMD_FORCE_SYNTH)) begin
					nxt_state = radio_ctrl_pkg::ST_SYNTH_ON; // RULE16
				end else if (rx_begin) begin
					nxt_state = radio_ctrl_pkg::ST_BUSY_RX; // RULE4
				end
			end
			radio_ctrl_pkg::ST_BUSY_RX: begin
				if (cmd == radio_ctrl_pkg::CMD_FORCE_IDLE) begin
					nxt_state = radio_ctrl_pkg::ST_IDLE; // RULE14
				end else if (cmd == radio_ctrl_pkg::CMD_FORCE_SYNTH) begin
					nxt_state = radio_ctrl_pkg::ST_SYNTH_ON; // RULE16
				end else if (i_rx_frame_done) begin
					nxt_state = (pend_idle_ff || (cmd == radio_ctrl_pkg::CMD_IDLE)) ?
					            radio_ctrl_pkg::ST_IDLE : radio_ctrl_pkg::ST_RX; // RULE24
				end else if (cmd == radio_ctrl_pkg::CMD_IDLE) begin
					nxt_pend_idle = 1'b1; // RULE15
				end
			end
			radio_ctrl_pkg::ST_BUSY_TX: begin
				if (cmd == radio_ctrl_pkg::CMD_FORCE_IDLE) begin
					nxt_state = radio_ctrl_pkg::ST_IDLE; // RULE14
				end else if (cmd == radio_ctrl_pkg::CMD_FORCE_SYNTH) begin
					nxt_state = radio_ctrl_pkg::ST_SYNTH_ON; // RULE16
				end else if (i_tx_frame_done) begin
					nxt_state = (pend_idle_ff || (cmd == radio_ctrl_pkg::CMD_IDLE)) ?
					            radio_ctrl_pkg::ST_IDLE : radio_ctrl_pkg::ST_SYNTH_ON; // RULE24
				end else if (cmd == radio_ctrl_pkg::CMD_IDLE) begin
					nxt_pend_idle = 1'b1; // RULE15
				end
			end
			default: begin
				nxt_state = radio_ctrl_pkg::ST_RESET;
			end
		endcase
		if (nxt_state != state_ff) begin
			nxt_pend_idle = 1'b0;
		end
	end

	// Module reset reaches sleep too, skipping the wake delay
	always_ff @(posedge i_ref_clk) begin
		if (any_rst) begin
			state_ff     <= radio_ctrl_pkg::ST_RESET; // RULE13
			pend_idle_ff <= 1'b0;
		end else if (i_ce) begin
			state_ff     <= nxt_state;
			pend_idle_ff <= nxt_pend_idle;
		end
	end

	// Counter restarts on every state change
	always_ff @(posedge i_ref_clk) begin
		if (any_rst) begin
			cnt_ff <= '0;
		end else if (i_ce) begin
			if (nxt_state != state_ff) begin
				cnt_ff <= '0;
			end else begin
				cnt_ff <= cnt_ff + radio_ctrl_pkg::CNT_W'(1);
			end
		end
	end

	// ----------------------------------------
	// Analog controls
	// ----------------------------------------
	logic pa_kill_ff;

	// Latched kill keeps the amplifier off for the rest of the frame
	always_ff @(posedge i_ref_clk) begin
		if (any_rst) begin
			pa_kill_ff <= 1'b0;
		end else if (i_ce) begin
			if (state_ff != radio_ctrl_pkg::ST_BUSY_TX) begin
				pa_kill_ff <= 1'b0;
			end else if (unlock_now) begin
				pa_kill_ff <= 1'b1; // RULE3
			end
		end
	end

	always_comb begin
		o_analog_reg_en = 1'b0;
		o_synth_en      = 1'b0;
		o_rx_en         = 1'b0;
		o_pa_en         = 1'b0;
		case (state_ff) // RULE19
			radio_ctrl_pkg::ST_REG_UP: begin
				o_analog_reg_en = 1'b1; // RULE20
			end
			radio_ctrl_pkg::ST_SYNTH_ON: begin
				o_analog_reg_en = 1'b1;
				o_synth_en      = 1'b1;
			end
			radio_ctrl_pkg::ST_RX, radio_ctrl_pkg::ST_BUSY_RX: begin
				o_analog_reg_en = 1'b1;
				o_synth_en      = 1'b1;
				o_rx_en         = 1'b1; // RULE21
			end
			radio_ctrl_pkg::ST_BUSY_TX: begin
				o_analog_reg_en = 1'b1;
				o_synth_en      = 1'b1;
				o_pa_en         = !pa_kill_ff && !unlock_now; // RULE3
			end
			default: begin
				o_analog_reg_en = 1'b0;
			end
		endcase
	end

	assign o_buf_clear    = (state_ff == radio_ctrl_pkg::ST_SLEEP); // RULE18
	assign o_cipher_clear = (state_ff == radio_ctrl_pkg::ST_SLEEP); // RULE18

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0]                        mask_ff;
	logic [radio_ctrl_pkg::CHAN_W-1:0] chan_ff;
	logic [7:0]                        hdr_ff;
	logic                              meas_busy_ff;
	logic                              meas_start_ff;
	logic                              meas_go;
	logic                              in_rx;

	assign in_rx   = (state_ff == radio_ctrl_pkg::ST_RX) ||
	                 (state_ff == radio_ctrl_pkg::ST_BUSY_RX);
	assign meas_go = wr_chan && i_wdata[radio_ctrl_pkg::POS_MEAS_REQ] && in_rx;

	always_ff @(posedge i_ref_clk) begin
		if (any_rst) begin
			mask_ff <= radio_ctrl_pkg::RST_MASK; // RULE6
			chan_ff <= radio_ctrl_pkg::RST_CHAN;
		end else if (i_ce) begin
			if (wr_mask) begin
				mask_ff <= i_wdata;
			end
			if (wr_chan) begin
				chan_ff <= i_wdata[radio_ctrl_pkg::CHAN_W-1:0];
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (any_rst) begin
			hdr_ff <= 8'h00;
		end else if (i_ce && rx_begin) begin
			hdr_ff <= i_rx_hdr_byte; // RULE4
		end
	end

	// A done strobe without a request is ignored
	always_ff @(posedge i_ref_clk) begin
		if (any_rst) begin
			meas_busy_ff  <= 1'b0;
			meas_start_ff <= 1'b0;
		end else if (i_ce) begin
			meas_start_ff <= meas_go;
			if (meas_go) begin
				meas_busy_ff <= 1'b1;
			end else if (i_meas_done) begin
				meas_busy_ff <= 1'b0;
			end
		end
	end

	assign o_meas_start = meas_start_ff;

	// ----------------------------------------
	// Events
	// ----------------------------------------
	logic [7:0] evt_ff;
	logic [7:0] ev_set;
	logic [7:0] ev_clr;
	logic [7:0] masked;
	logic [7:0] top_bit;
	logic [2:0] top_idx;

	always_comb begin
		ev_set = 8'h00;
		ev_set[radio_ctrl_pkg::EV_AWAKE]    = (nxt_state == radio_ctrl_pkg::ST_IDLE) &&
		                                      ((state_ff == radio_ctrl_pkg::ST_WAKE) ||
		                                       (state_ff == radio_ctrl_pkg::ST_RESET)); // RULE2
		ev_set[radio_ctrl_pkg::EV_TX_DONE]  = (state_ff == radio_ctrl_pkg::ST_BUSY_TX) &&
		                                      i_tx_frame_done;
		ev_set[radio_ctrl_pkg::EV_ADDR]     = (state_ff == radio_ctrl_pkg::ST_BUSY_RX) &&
		                                      i_addr_match;
		ev_set[radio_ctrl_pkg::EV_MEAS]     = meas_busy_ff && i_meas_done; // RULE5
		ev_set[radio_ctrl_pkg::EV_RX_DONE]  = (state_ff == radio_ctrl_pkg::ST_BUSY_RX) &&
		                                      i_rx_frame_done;
		ev_set[radio_ctrl_pkg::EV_RX_START] = rx_begin; // RULE4
		ev_set[radio_ctrl_pkg::EV_UNLOCK]   = unlock_now; // RULE3
		ev_set[radio_ctrl_pkg::EV_LOCK]     = lock_now; // RULE20
	end

	assign masked = evt_ff & mask_ff; // RULE22

	// Lowest bit is the lowest vector, hence the highest priority
	always_comb begin
		top_bit = 8'h00;
		top_idx = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (masked[i]) begin
				top_bit = 8'h00;
				top_bit[i] = 1'b1;
				top_idx = 3'(i); // RULE1
			end
		end
	end

	assign ev_clr = (wr_stat ? i_wdata : 8'h00) | (i_vec_ack ? top_bit : 8'h00);

	// Set beats clear so an event in the clearing cycle is kept
	always_ff @(posedge i_ref_clk) begin
		if (any_rst) begin
			evt_ff <= 8'h00;
		end else if (i_ce) begin
			evt_ff <= (evt_ff & ~ev_clr) | ev_set; // RULE22
		end
	end

	assign o_event_pending = masked;
	assign o_irq_req       = |masked;
	assign o_irq_vector    = radio_ctrl_pkg::VEC_BASE + {4'h0, top_idx}; // RULE1

	// ----------------------------------------
	// Status and read port
	// ----------------------------------------
	logic [radio_ctrl_pkg::CMD_W-1:0] status;
	logic [7:0]                       rdata_ff;

	always_comb begin
		case (state_ff) // RULE10
			radio_ctrl_pkg::ST_SLEEP:    status = radio_ctrl_pkg::STS_SLEEP;
			radio_ctrl_pkg::ST_IDLE:     status = radio_ctrl_pkg::STS_IDLE;
			radio_ctrl_pkg::ST_SYNTH_ON: status = radio_ctrl_pkg::STS_SYNTH_ON;
			radio_ctrl_pkg::ST_RX:       status = radio_ctrl_pkg::STS_RX;
			radio_ctrl_pkg::ST_BUSY_RX:  status = radio_ctrl_pkg::STS_BUSY_RX;
			radio_ctrl_pkg::ST_BUSY_TX:  status = radio_ctrl_pkg::STS_BUSY_TX;
			default:                     status = radio_ctrl_pkg::STS_TRANSIT;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			rdata_ff <= 8'h00;
		end else if (i_ce) begin
			rdata_ff <= 8'h00;
			if (i_rd) begin
				if (i_addr == radio_ctrl_pkg::OFS_STATE_CMD) begin
					rdata_ff <= {3'h0, status}; // RULE9
				end else if (i_addr == radio_ctrl_pkg::OFS_PIN_CTRL) begin
					rdata_ff <= {6'h00, sleep_tx_ff, 1'b0};
				end else if (i_addr == radio_ctrl_pkg::OFS_EVT_MASK) begin
					rdata_ff <= mask_ff;
				end else if (i_addr == radio_ctrl_pkg::OFS_EVT_STAT) begin
					rdata_ff <= evt_ff;
				end else if (i_addr == radio_ctrl_pkg::OFS_CHAN) begin
					rdata_ff <= {meas_busy_ff, 2'h0, chan_ff};
				end else if (i_addr == radio_ctrl_pkg::OFS_PART) begin
					rdata_ff <= radio_ctrl_pkg::ID_PART; // RULE8
				end else if (i_addr == radio_ctrl_pkg::OFS_VERSION) begin
					rdata_ff <= radio_ctrl_pkg::ID_VERSION; // RULE8
				end else if (i_addr == radio_ctrl_pkg::OFS_MAKER_LO) begin
					rdata_ff <= radio_ctrl_pkg::ID_MAKER_LO; // RULE8
				end else if (i_addr == radio_ctrl_pkg::OFS_MAKER_HI) begin
					rdata_ff <= radio_ctrl_pkg::ID_MAKER_HI; // RULE8
				end else if (i_addr == radio_ctrl_pkg::OFS_HDR) begin
					rdata_ff <= hdr_ff;
				end
			end
		end
	end

	assign o_rdata = rdata_ff;

endmodule

`default_nettype wire

// ==== verif/radio_far_end.sv ====
`default_nettype none

module radio_far_end #(
	parameter int LOCK_CYC = 10,
	parameter int TX_CYC   = 20
) (
	input  wire logic i_ref_clk,
	input  wire logic i_synth_en,
	input  wire logic i_pa_en,
	input  wire logic i_meas_start,
	input  wire logic i_kill,
	output logic      o_synth_lock,
	output logic      o_tx_done,
	output logic      o_meas_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] lock_cnt_ff = 8'h00;
	logic [7:0] tx_cnt_ff   = 8'h00;
	logic [2:0] meas_ff     = 3'h0;
	// ----
	// Front end
	// ----
	// Kill drops lock without a clock, as a real loss would
	always_ff @(posedge i_ref_clk) begin
		if (!i_synth_en)
			lock_cnt_ff <= 8'h00;
		else if (lock_cnt_ff != 8'(LOCK_CYC))
			lock_cnt_ff <= lock_cnt_ff + 8'h01;
	end
	assign o_synth_lock = (lock_cnt_ff == 8'(LOCK_CYC)) && !i_kill;
	always_ff @(posedge i_ref_clk) begin
		tx_cnt_ff <= i_pa_en ? tx_cnt_ff + 8'h01 : 8'h00;
		meas_ff   <= {meas_ff[1:0], i_meas_start};
	end
	assign o_tx_done   = tx_cnt_ff == 8'(TX_CYC);
	assign o_meas_done = meas_ff[2];
endmodule

`default_nettype wire

// ==== verif/radio_state_control_irq_properties.sv ====
`default_nettype none

module radio_ctrl_checker (
	input wire logic       i_ref_clk,
	input wire logic       i_rstn,
	input wire logic       i_rd,
	input wire logic       i_synth_lock,
	input wire logic [7:0] o_rdata,
	input wire logic       o_meas_start,
	input wire logic       o_analog_reg_en,
	input wire logic       o_synth_en,
	input wire logic       o_rx_en,
	input wire logic       o_pa_en,
	input wire logic       o_buf_clear,
	input wire logic       o_cipher_clear,
	input wire logic [7:0] o_event_pending,
	input wire logic       o_irq_req,
	input wire logic [6:0] o_irq_vector
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Properties
	// ----
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	a_vec_lowest: assert property (o_event_pending[0] |-> o_irq_vector == 7'h39)
		else $error("vector not lowest pending");
	a_vec_awake: assert property (o_event_pending == 8'h80 |-> o_irq_vector == 7'h40)
		else $error("awake vector wrong");
	a_irq_any: assert property (o_irq_req == (o_event_pending != 8'h00))
		else $error("request not tied to pending");
	a_mask_cleared: assert property ($rose(i_rstn) |=> o_event_pending == 8'h00)
		else $error("event forwarded after reset");
	a_pa_unlock: assert property ($fell(i_synth_lock) |-> !o_pa_en)
		else $error("amplifier on after unlock");
	a_sleep_dark: assert property (o_buf_clear |-> o_cipher_clear && !o_synth_en)
		else $error("sleep clears wrong");
	a_reg_first: assert property ($rose(o_analog_reg_en) |-> !o_synth_en)
		else $error("synth before regulator");
	a_rx_chain: assert property (o_rx_en |-> o_synth_en && o_analog_reg_en)
		else $error("receiver without synth");
	a_rdata_once: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data not one cycle");
	a_meas_pulse: assert property (o_meas_start |=> !o_meas_start)
		else $error("measurement start too long");
	c_pa: cover property (o_pa_en);
	c_sleep: cover property (o_buf_clear);
	c_lock_irq: cover property (o_irq_req && o_irq_vector == 7'h39);
endmodule

bind radio_state_control_irq radio_ctrl_checker u_radio_ctrl_checker (.i_ref_clk, .i_rstn,
	.i_rd, .i_synth_lock, .o_rdata, .o_meas_start, .o_analog_reg_en, .o_synth_en, .o_rx_en,
	.o_pa_en, .o_buf_clear, .o_cipher_clear, .o_event_pending, .o_irq_req, .o_irq_vector);

`default_nettype wire

// ==== verif/test_radio_state_control_irq.sv ====
`default_nettype none

module test_radio_state_control_irq;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk = 1'b0;
	logic       rstn    = 1'b0;
	logic       wr      = 1'b0;
	logic       rd      = 1'b0;
	logic       kill    = 1'b0;
	logic [7:0] addr    = 8'h00;
	logic [7:0] wdata   = 8'h00;
	logic [3:0] pls     = 4'h0;
	logic [7:0] rdata, pend;
	logic [6:0] vec;
	logic       lock, txd, msd, ms, are, sen, rxe, pae, bclr, cclr, irq;
	int         err_total = 0;
	int         n_checks  = 0;
	// Address in the upper byte, expected read in the lower
	logic [15:0] rows [9] = '{16'h055A, 16'h0601, 16'h073C, 16'h0800, 16'h0200,
		16'h040B, 16'h0008, 16'h0380, 16'h2000};
	always #12.5 ref_clk = ~ref_clk;
	radio_state_control_irq #(.WAKE_CYC(8)) u_radio_state_control_irq (.i_ref_clk(ref_clk),
		.i_rstn(rstn), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_synth_lock(lock), .i_phr_valid(pls[0]), .i_rx_hdr_byte(8'hA5),
		.i_addr_match(pls[1]), .i_rx_frame_done(pls[2]), .i_tx_frame_done(txd),
		.i_meas_done(msd), .i_vec_ack(pls[3]), .o_meas_start(ms), .o_analog_reg_en(are),
		.o_synth_en(sen), .o_rx_en(rxe), .o_pa_en(pae), .o_buf_clear(bclr),
		.o_cipher_clear(cclr), .o_event_pending(pend), .o_irq_req(irq), .o_irq_vector(vec));
	radio_far_end u_radio_far_end (.i_ref_clk(ref_clk), .i_synth_en(sen), .i_pa_en(pae),
		.i_meas_start(ms), .i_kill(kill), .o_synth_lock(lock), .o_tx_done(txd),
		.o_meas_done(msd));
	// ----
	// Tasks
	// ----
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge ref_clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd <= 1'b0;
		@(negedge ref_clk);
		chk(what, exp, rdata);
	endtask
	// Polls status; a bound that runs out counts one mismatch and ends the test
	task automatic wait_sts(input logic [7:0] s);
		int i;
		for (i = 0; i < 100 && rdata !== s; i++) begin
			@(posedge ref_clk);
			rd   <= 1'b1;
			addr <= 8'h00;
			@(posedge ref_clk);
			rd <= 1'b0;
			@(negedge ref_clk);
		end
		chk("status", s, rdata);
		if (rdata !== s)
			finish_test();
	endtask
	task automatic wait_ev(input int b);
		int i;
		for (i = 0; i < 200 && pend[b] !== 1'b1; i++)
			@(negedge ref_clk);
		chk("event", 8'h01, {7'h0, pend[b]});
		if (pend[b] !== 1'b1)
			finish_test();
	endtask
	task automatic pulse(input int b);
		@(posedge ref_clk);
		pls <= 4'(1 << b);
		@(posedge ref_clk);
		pls <= 4'h0;
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		foreach (rows[i]) rc(rows[i][15:8], rows[i][7:0], "register");
		wr_reg(8'h05, 8'hFF);
		rc(8'h05, 8'h5A, "part");
		chk("pending", 8'h00, pend);
		wr_reg(8'h02, 8'hFF);
		@(negedge ref_clk);
		chk("vector", 8'h40, {1'b0, vec});
		chk("irq", 8'h01, {7'h0, irq});
		wr_reg(8'h00, 8'h09);
		rc(8'h00, 8'h1F, "status");
		chk("regulator", 8'h01, {7'h0, are & ~sen});
		wait_sts(8'h09);
		wait_ev(0);
		chk("vector", 8'h39, {1'b0, vec});
		pulse(3);
		@(negedge ref_clk);
		chk("pending", 8'h80, pend);
		wr_reg(8'h03, 8'hFF);
		wr_reg(8'h00, 8'h06);
		rc(8'h00, 8'h06, "status");
		chk("receiver", 8'h01, {7'h0, rxe});
		wr_reg(8'h04, 8'h8B);
		wait_ev(4);
		pulse(0);
		rc(8'h00, 8'h01, "status");
		rc(8'h09, 8'hA5, "header");
		chk("vector", 8'h3B, {1'b0, vec});
		pulse(1);
		wr_reg(8'h00, 8'h08);
		rc(8'h00, 8'h01, "status");
		pulse(2);
		wait_sts(8'h08);
		chk("pending", 8'h3C, pend & 8'h3C);
		wr_reg(8'h03, 8'hFF);
		wr_reg(8'h00, 8'h09);
		wait_sts(8'h09);
		wr_reg(8'h00, 8'h02);
		wait_sts(8'h02);
		wait_sts(8'h09);
		wait_ev(6);
		wr_reg(8'h01, 8'h02);
		wait_sts(8'h02);
		@(posedge ref_clk);
		kill <= 1'b1;
		@(negedge ref_clk);
		chk("amplifier", 8'h00, {7'h0, pae});
		wait_ev(1);
		rc(8'h01, 8'h02, "pin");
		wr_reg(8'h00, 8'h03);
		rc(8'h00, 8'h08, "status");
		kill <= 1'b0;
		wr_reg(8'h01, 8'h00);
		wr_reg(8'h01, 8'h02);
		wait_sts(8'h0F);
		chk("clear", 8'h01, {7'h0, bclr & cclr});
		wr_reg(8'h01, 8'h00);
		wait_sts(8'h08);
		wait_ev(7);
		wr_reg(8'h01, 8'h01);
		rc(8'h02, 8'h00, "mask");
		rc(8'h01, 8'h00, "pin");
		wait_sts(8'h08);
		finish_test();
	end
endmodule

`default_nettype wire
